/* File: verilog/pmc_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the power-mode clock sequencer.
// Assumes: A 100 MHz system clock.
// Notes:   Definitions only; included by bare name.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

`define PMC_CLK_PERIOD_NS 10
`define PMC_ADDR_OSC_CTRL 4'h0
`define PMC_ADDR_TMR_CTRL 4'h4
`define PMC_ADDR_STATUS   4'h8
`define PMC_OSC_HALT_BIT  7
`define PMC_OSC_IFREQ_HI  6
`define PMC_OSC_IFREQ_LO  4
`define PMC_OSC_PRDY_BIT  3
`define PMC_OSC_ISTB_BIT  2
`define PMC_TMR_ACT_BIT   6
`define PMC_TMR_EN_BIT    3
`define PMC_OSC_CTRL_RST  8'h00
`define PMC_IFREQ_FAST    3'h7
`define PMC_OST_COUNT     11'h400
`define PMC_SWITCH_LAST   4'h7
`define PMC_CORE_WAIT_NS  5000
`define PMC_PLL_LOCK_NS   2000000
`define PMC_POWER_UP_TIMER_NS       1000000
`define PMC_CORE_WAIT_CYC ((`PMC_CORE_WAIT_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_PLL_LOCK_CYC  ((`PMC_PLL_LOCK_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_POWER_UP_TIMER_CYC      ((`PMC_POWER_UP_TIMER_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)

`endif

/* File: verilog/pmc_pkg.sv */
// Purpose: Types shared by the power-mode clock sequencer.
// Assumes: Nothing beyond the defs header.
// Notes:   Enumerations carry no explicit codes.
package pmc_pkg;

  typedef enum logic [3:0] {
    OSC_LOW_POWER_XTAL, OSC_MEDIUM_XTAL, OSC_HIGH_SPEED_XTAL, OSC_FAST_XTAL_PLL,
    OSC_EXT_CLOCK_INPUT, OSC_EXT_CLOCK_GPIO, OSC_RES_CAP, OSC_RES_CAP_GPIO,
    OSC_INTERNAL_CLKOUT, OSC_INTERNAL_GPIO
  } pmc_osc_mode_type;

  typedef enum logic [1:0] {SRC_PRIMARY, SRC_TIMER, SRC_INTERNAL, SRC_NONE} pmc_src_type;

  typedef enum logic [2:0] {
    MODE_MAIN_RUN, MODE_TIMER_RUN, MODE_INT_RUN,
    MODE_MAIN_IDLE, MODE_TIMER_IDLE, MODE_INT_IDLE, MODE_SLEEP
  } pmc_mode_type;

  typedef enum logic [2:0] {
    SEQ_SAMPLE, SEQ_POWERUP, SEQ_ACTIVE, SEQ_STOP, SEQ_SWITCH, SEQ_SLEEP, SEQ_WAKE
  } pmc_seq_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pmc_bus_req_type;

  typedef struct packed {
    logic o;
    logic oe;
  } pmc_pin_type;

endpackage

/* File: verilog/pmc_sequencer.sv */
// Purpose: Start-up reset hold, power-mode selection and glitch-free clock source switching.
// Assumes: Oscillator ticks and the internal settle level are asynchronous; core strobes share clock.
// Notes:   Clock gating itself is done by the enables this block drives.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pmc_defs.svh"

module pmc_sequencer #(
  parameter int unsigned POWER_UP_TIMER_CYCLES = `PMC_POWER_UP_TIMER_CYC,
  parameter int unsigned PLL_CYCLES  = `PMC_PLL_LOCK_CYC
) (
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  input  wire pmc_pkg::pmc_bus_req_type   busReq,
  output logic [7:0]                      rdData,
  input  wire pmc_pkg::pmc_osc_mode_type  cfgOscMode,
  input  wire logic                       cfgPwrtEnable,
  input  wire logic [3:0]                 oscIn,
  input  wire logic                       sleepReq,
  input  wire logic                       instrStart,
  input  wire logic                       wakeEvent,
  input  wire logic                       watchdogTimeout,
  input  wire logic                       instClk,
  input  wire logic                       gpio6Out,
  input  wire logic                       gpio6Oe,
  output logic                            holdReset,
  output logic                            cpuReady,
  output logic                            cpuClkEn,
  output logic                            periphClkEn,
  output pmc_pkg::pmc_src_type            clkSource,
  output logic                            priOscEnable,
  output logic                            feedbackEnable,
  output pmc_pkg::pmc_pin_type            clkOutPin
);
  import pmc_pkg::*;

  // ********************************************************************
  // Synchronisers and edge detection
  // ********************************************************************
  logic [3:0] oscLvl;
  logic [2:0] oscEdge;

  for (genvar i = 0; i < 4; i++)
  begin : gSync
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge clock)
    begin
      if (sys_rst)
      begin
        s1_reg <= 1'h0;
        s2_reg <= 1'h0;
        s3_reg <= 1'h0;
      end
      else
      begin
        s1_reg <= oscIn[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
      end
    end
    assign oscLvl[i] = s2_reg;
    if (i < 3)
    begin : gEdge
      assign oscEdge[i] = s2_reg & ~s3_reg;
    end
  end

  // ********************************************************************
  // State and configuration
  // ********************************************************************
  pmc_seq_type      state_reg, stateNext;
  pmc_mode_type     mode_reg, modeNext, pendMode_reg, pendModeNext, tgtMode;
  pmc_src_type      curSrc_reg, srcNext, pendSrc_reg, pendSrcNext, tgtSrc;
  pmc_osc_mode_type cfgMode_reg;
  logic             cfgPwrt_reg;
  logic [7:0]       oscCtrl_reg;
  logic             tmrEn_reg;
  logic             pendHalt_reg, pendHaltNext, pendSleep_reg, pendSleepNext;
  logic             holdNext, cpuNext, perNext, priEnNext;
  logic             prdy_reg, istb_reg, tact_reg;
  logic [10:0]      ostCnt_reg;
  logic [31:0]      pllCnt_reg, pwrtCnt_reg;
  logic [9:0]       coreCnt_reg;
  logic [3:0]       swCnt_reg;

  wire crystal   = cfgMode_reg inside {OSC_LOW_POWER_XTAL, OSC_MEDIUM_XTAL,
                                       OSC_HIGH_SPEED_XTAL, OSC_FAST_XTAL_PLL};
  wire isPll     = cfgMode_reg == OSC_FAST_XTAL_PLL;
  wire intPri    = cfgMode_reg inside {OSC_INTERNAL_CLKOUT, OSC_INTERNAL_GPIO};
  wire clkoutMd  = cfgMode_reg inside {OSC_RES_CAP, OSC_INTERNAL_CLKOUT, OSC_EXT_CLOCK_INPUT};
  wire gpioMd    = cfgMode_reg inside {OSC_RES_CAP_GPIO, OSC_INTERNAL_GPIO, OSC_EXT_CLOCK_GPIO};
  wire wakeAny   = wakeEvent | watchdogTimeout;
  wire ostDone   = !crystal || ostCnt_reg == `PMC_OST_COUNT;
  wire pllDone   = !isPll || pllCnt_reg == PLL_CYCLES;
  wire priStable = ostDone && pllDone;
  wire pwrtDone  = !cfgPwrt_reg || pwrtCnt_reg == POWER_UP_TIMER_CYCLES;
  wire coreDone  = coreCnt_reg == 10'(`PMC_CORE_WAIT_CYC);

  // ********************************************************************
  // Sleep target decode
  // ********************************************************************
  wire [1:0] choice  = oscCtrl_reg[1:0];
  wire       tgtHalt = oscCtrl_reg[`PMC_OSC_HALT_BIT];
  wire       tgtSleep = !tgtHalt && choice == 2'h0;
  assign tgtSrc = choice[1] ? SRC_INTERNAL :
                  !choice[0] ? SRC_PRIMARY :
                  tmrEn_reg ? SRC_TIMER : curSrc_reg;
  assign tgtMode = tgtSleep ? MODE_SLEEP :
                   tgtSrc == SRC_PRIMARY ? (tgtHalt ? MODE_MAIN_IDLE : MODE_MAIN_RUN) :
                   tgtSrc == SRC_TIMER ? (tgtHalt ? MODE_TIMER_IDLE : MODE_TIMER_RUN) :
                   (tgtHalt ? MODE_INT_IDLE : MODE_INT_RUN);
  wire sleepTake = state_reg == SEQ_ACTIVE && !wakeAny && sleepReq && cpuClkEn;
  wire newEdge   = pendSrc_reg == SRC_PRIMARY ? oscEdge[0] :
                   pendSrc_reg == SRC_TIMER ? oscEdge[1] : oscEdge[2];
  wire gateOk    = pendSrc_reg != SRC_PRIMARY || priStable;
  wire swDone    = swCnt_reg == `PMC_SWITCH_LAST && newEdge && gateOk;

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  always_comb
  begin
    stateNext     = state_reg;
    modeNext      = mode_reg;
    srcNext       = curSrc_reg;
    pendSrcNext   = pendSrc_reg;
    pendModeNext  = pendMode_reg;
    pendHaltNext  = pendHalt_reg;
    pendSleepNext = pendSleep_reg;
    holdNext      = holdReset;
    cpuNext       = cpuClkEn;
    perNext       = periphClkEn;
    priEnNext     = priOscEnable;
    case (state_reg)
      SEQ_SAMPLE:
        stateNext = SEQ_POWERUP;
      SEQ_POWERUP:
        if (pwrtDone && priStable)
        begin
          holdNext  = 1'h0;
          cpuNext   = 1'h1;
          perNext   = 1'h1;
          stateNext = SEQ_ACTIVE;
        end
      SEQ_ACTIVE:
        if (wakeAny && mode_reg != MODE_MAIN_RUN)
        begin
          cpuNext   = 1'h1;
          priEnNext = 1'h1;
          stateNext = SEQ_WAKE;
        end
        else if (sleepTake)
        begin
          pendSrcNext   = tgtSrc;
          pendModeNext  = tgtMode;
          pendHaltNext  = tgtHalt;
          pendSleepNext = tgtSleep;
          stateNext     = SEQ_STOP;
        end
      SEQ_STOP:
        if (instrStart)
        begin
          cpuNext   = 1'h0;
          perNext   = 1'h0;
          priEnNext = pendSrc_reg == SRC_PRIMARY && !pendSleep_reg;
          if (pendSleep_reg)
          begin
            modeNext  = MODE_SLEEP;
            srcNext   = SRC_NONE;
            stateNext = SEQ_SLEEP;
          end
          else
            stateNext = SEQ_SWITCH;
        end
      SEQ_SWITCH:
        if (swDone)
        begin
          srcNext   = pendSrc_reg;
          modeNext  = pendMode_reg;
          perNext   = 1'h1;
          cpuNext   = !pendHalt_reg;
          stateNext = SEQ_ACTIVE;
        end
      SEQ_SLEEP:
        if (wakeAny)
        begin
          priEnNext = 1'h1;
          stateNext = SEQ_WAKE;
        end
      SEQ_WAKE:
        if (priStable)
        begin
          if (curSrc_reg == SRC_PRIMARY)
          begin
            modeNext  = MODE_MAIN_RUN;
            cpuNext   = 1'h1;
            perNext   = 1'h1;
            stateNext = SEQ_ACTIVE;
          end
          else
          begin
            pendSrcNext  = SRC_PRIMARY;
            pendModeNext = MODE_MAIN_RUN;
            pendHaltNext = 1'h0;
            cpuNext      = 1'h0;
            perNext      = 1'h0;
            stateNext    = SEQ_SWITCH;
          end
        end
      default:
        stateNext = SEQ_SAMPLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg     <= SEQ_SAMPLE;
      mode_reg      <= MODE_MAIN_RUN;
      curSrc_reg    <= SRC_PRIMARY;
      pendSrc_reg   <= SRC_PRIMARY;
      pendMode_reg  <= MODE_MAIN_RUN;
      pendHalt_reg  <= 1'h0;
      pendSleep_reg <= 1'h0;
      holdReset     <= 1'h1;
      cpuClkEn      <= 1'h0;
      periphClkEn   <= 1'h0;
      priOscEnable  <= 1'h1;
    end
    else
    begin
      state_reg     <= stateNext;
      mode_reg      <= modeNext;
      curSrc_reg    <= srcNext;
      pendSrc_reg   <= pendSrcNext;
      pendMode_reg  <= pendModeNext;
      pendHalt_reg  <= pendHaltNext;
      pendSleep_reg <= pendSleepNext;
      holdReset     <= holdNext;
      cpuClkEn      <= cpuNext;
      periphClkEn   <= perNext;
      priOscEnable  <= priEnNext;
    end
  end

  // ********************************************************************
  // Start-up and switch counters
  // ********************************************************************
  // Oscillator counts restart whenever the primary is off, so wake reuses them.
  always_ff @(posedge clock)
  begin
    if (sys_rst || !priOscEnable)
      ostCnt_reg <= 11'h000;
    else if (!ostDone && oscEdge[0])
      ostCnt_reg <= ostCnt_reg + 11'h001;
    if (sys_rst || !priOscEnable || !ostDone)
      pllCnt_reg <= 32'h0;
    else if (!pllDone)
      pllCnt_reg <= pllCnt_reg + 32'h1;
    if (sys_rst || state_reg == SEQ_SAMPLE)
      pwrtCnt_reg <= 32'h0;
    else if (!pwrtDone)
      pwrtCnt_reg <= pwrtCnt_reg + 32'h1;
    if (sys_rst)
      coreCnt_reg <= 10'h000;
    else if (!coreDone)
      coreCnt_reg <= coreCnt_reg + 10'h001;
    if (sys_rst || state_reg != SEQ_SWITCH)
      swCnt_reg <= 4'h0;
    else if (newEdge && gateOk)
      swCnt_reg <= swCnt_reg + 4'h1;
  end

  // ********************************************************************
  // Flags, pins and registers
  // ********************************************************************
  wire live      = state_reg == SEQ_ACTIVE || state_reg == SEQ_WAKE;
  wire prdyNext  = live && curSrc_reg == SRC_PRIMARY && priStable;
  wire istbNext  = live && oscLvl[3]
                   && oscCtrl_reg[`PMC_OSC_IFREQ_HI:`PMC_OSC_IFREQ_LO] == `PMC_IFREQ_FAST
                   && (curSrc_reg == SRC_INTERNAL || (curSrc_reg == SRC_PRIMARY && intPri));
  wire tactNext  = live && curSrc_reg == SRC_TIMER;
  wire asleep    = state_reg == SEQ_SLEEP;
  wire pinONext  = gpioMd ? gpio6Out : (clkoutMd && !asleep && instClk);
  wire pinOeNext = gpioMd ? gpio6Oe : clkoutMd;
  wire wrOsc     = busReq.wr && busReq.addr == `PMC_ADDR_OSC_CTRL;
  wire wrTmr     = busReq.wr && busReq.addr == `PMC_ADDR_TMR_CTRL;
  wire [7:0] oscRd = {oscCtrl_reg[7:4], prdy_reg, istb_reg, oscCtrl_reg[1:0]};
  wire [7:0] tmrRd = {1'h0, tact_reg, 2'h0, tmrEn_reg, 3'h0};
  wire [7:0] stRd  = {1'h0, mode_reg, 2'h0, curSrc_reg};
  wire [7:0] rdSel = !busReq.rd ? 8'h00 :
                     busReq.addr == `PMC_ADDR_OSC_CTRL ? oscRd :
                     busReq.addr == `PMC_ADDR_TMR_CTRL ? tmrRd :
                     busReq.addr == `PMC_ADDR_STATUS ? stRd : 8'h00;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      oscCtrl_reg    <= `PMC_OSC_CTRL_RST;
      tmrEn_reg      <= 1'h0;
      cfgMode_reg    <= OSC_LOW_POWER_XTAL;
      cfgPwrt_reg    <= 1'h0;
      prdy_reg       <= 1'h0;
      istb_reg       <= 1'h0;
      tact_reg       <= 1'h0;
      rdData         <= 8'h00;
      feedbackEnable <= 1'h0;
      clkOutPin      <= '0;
      cpuReady       <= 1'h0;
    end
    else
    begin
      if (state_reg == SEQ_SAMPLE)
      begin
        cfgMode_reg <= cfgOscMode;
        cfgPwrt_reg <= cfgPwrtEnable;
      end
      if (wrOsc)
        oscCtrl_reg <= {busReq.wdata[7:4], 2'h0, busReq.wdata[1:0]};
      if (wrTmr)
        tmrEn_reg <= busReq.wdata[`PMC_TMR_EN_BIT];
      prdy_reg       <= prdyNext;
      istb_reg       <= istbNext;
      tact_reg       <= tactNext;
      rdData         <= rdSel;
      feedbackEnable <= crystal && priEnNext;
      clkOutPin      <= '{o: pinONext, oe: pinOeNext};
      cpuReady       <= coreDone && !holdNext;
    end
  end

  assign clkSource = curSrc_reg;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_sleep_take;
    sleepTake && tgtSleep;
  endsequence
  sequence s_stop_edge;
    state_reg == SEQ_STOP && instrStart;
  endsequence

  a_ost_hold_count: assert property ($fell(holdReset) && crystal |-> ostCnt_reg == `PMC_OST_COUNT)
    else $error("Reset released before the oscillator count ended.");
  a_pll_extra_wait: assert property ($fell(holdReset) && isPll |-> pllCnt_reg == PLL_CYCLES)
    else $error("Reset released before the PLL lock wait ended.");
  a_power_up_timer_delay: assert property ($fell(holdReset) && cfgPwrt_reg |-> pwrtCnt_reg == POWER_UP_TIMER_CYCLES)
    else $error("Reset released before the power-up delay ended.");
  a_core_ready_wait: assert property ($rose(cpuReady) |-> coreDone && !holdReset)
    else $error("Core ready before its wait ended.");
  a_clkout_sleep: assert property (asleep && clkoutMd |=> !clkOutPin.o && clkOutPin.oe)
    else $error("Clock-out pin not low in sleep.");
  a_feedback_off: assert property (asleep && crystal |-> !feedbackEnable)
    else $error("Feedback inverter active in sleep.");
  a_full_sleep: assert property (s_stop_edge ##0 pendSleep_reg
    |=> asleep && clkSource == SRC_NONE && !cpuClkEn && !periphClkEn)
    else $error("All-zero sleep did not stop every clock.");
  a_sleep_pending: assert property (s_sleep_take |=> pendSleep_reg && state_reg == SEQ_STOP)
    else $error("All-zero sleep request did not arm full sleep.");
  a_choice_no_effect: assert property (wrOsc && state_reg == SEQ_ACTIVE && !wakeAny && !sleepTake
    |=> $stable(clkSource) && $stable(mode_reg))
    else $error("Choice write changed the active clock.");
  a_stop_next_cycle: assert property (s_stop_edge |=> !cpuClkEn && !periphClkEn)
    else $error("Clocks not stopped at the next instruction cycle.");
  a_switch_pulses: assert property ($rose(periphClkEn) && $past(state_reg) == SEQ_SWITCH
    |-> $past(swCnt_reg) == 4'h7)
    else $error("New clock released before eight edges.");
  a_flag_onehot: assert property (mode_reg != MODE_MAIN_RUN && mode_reg != MODE_MAIN_IDLE
    |-> $onehot0({prdy_reg, istb_reg, tact_reg}))
    else $error("More than one source flag set.");
  a_timer_ignored: assert property (sleepTake && choice == 2'h1 && !tmrEn_reg
    |=> pendSrc_reg == $past(curSrc_reg))
    else $error("Disabled timer source was selected.");

endmodule

/* File: testbench/pmc_osc_model.sv */
// Purpose: Stand-in for the oscillator sources and the core's instruction cycle timing.
// Assumes: Every tick stays high and low for at least one system clock.
// Notes:   The primary tick stands still while its enable is low, as a stopped crystal would.
`timescale 1ns/1ps
module pmc_osc_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       priOscEnable,
  output logic [3:0]      oscIn,
  output logic            instrStart,
  output logic            instClk
);
  logic [1:0] priCnt;
  logic [2:0] tmrCnt;
  logic [1:0] cycCnt;
  logic [4:0] settleCnt;
  // ****************************************
  // Oscillator ticks and instruction cycles
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      priCnt <= 2'h0;
      tmrCnt <= 3'h0;
      cycCnt <= 2'h0;
      settleCnt <= 5'h00;
    end
    else
    begin
      if (priOscEnable)
        priCnt <= priCnt + 2'h1;
      tmrCnt <= (tmrCnt == 3'h5) ? 3'h0 : tmrCnt + 3'h1;
      cycCnt <= cycCnt + 2'h1;
      if (!settleCnt[4])
        settleCnt <= settleCnt + 5'h01;
    end
  end
  // The timer tick is the slowest, so a switch to it shows the longest pause.
  assign oscIn = {settleCnt[4], cycCnt[1], (tmrCnt > 3'h2), priCnt[1]};
  assign instrStart = (cycCnt == 2'h3);
  assign instClk = cycCnt[1];
endmodule

/* File: testbench/power_mode_clock_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the power-mode clock sequencer.
// Assumes: Shortened power-up and PLL counts keep the run brief.
// Notes:   Sleep modes run from a table; start-up precedes it and odd cases follow by hand.
`timescale 1ns/1ps
`include "pmc_defs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
`define WAITC(c, lim) begin w = 0; while ((c) !== 1'b1 && w < lim) begin @(posedge clock); #1; w++; end \
  if ((c) !== 1'b1) begin errors++; end_sim(); end end
module power_mode_clock_sequencer_tb_top;
  import pmc_pkg::*;
  typedef struct packed {
    logic halt; logic [1:0] ch; pmc_mode_type mode; pmc_src_type src; logic cpu; logic per;
  } pmc_row_type;
  logic             clock, sys_rst, sleepReq, wakeEvent, watchdogTimeout, cfgPwrtEnable;
  logic             instrStart, instClk, gpio6Out, gpio6Oe, holdReset, cpuReady;
  logic             cpuClkEn, periphClkEn, priOscEnable, feedbackEnable;
  logic [7:0]       rdData, d;
  logic [3:0]       oscIn;
  pmc_bus_req_type  busReq;
  pmc_osc_mode_type cfgOscMode;
  pmc_src_type      clkSource;
  pmc_pin_type      clkOutPin;
  pmc_row_type      rows[7];
  pmc_row_type      r;
  int               errors, checks, n, m, w;
  pmc_sequencer #(.POWER_UP_TIMER_CYCLES(20), .PLL_CYCLES(30)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .busReq(busReq), .rdData(rdData), .cfgOscMode(cfgOscMode),
    .cfgPwrtEnable(cfgPwrtEnable), .oscIn(oscIn), .sleepReq(sleepReq), .instrStart(instrStart),
    .wakeEvent(wakeEvent), .watchdogTimeout(watchdogTimeout), .instClk(instClk), .gpio6Out(gpio6Out),
    .gpio6Oe(gpio6Oe), .holdReset(holdReset), .cpuReady(cpuReady), .cpuClkEn(cpuClkEn),
    .periphClkEn(periphClkEn), .clkSource(clkSource), .priOscEnable(priOscEnable),
    .feedbackEnable(feedbackEnable), .clkOutPin(clkOutPin));
  pmc_osc_model osc_u (.clock(clock), .sys_rst(sys_rst), .priOscEnable(priOscEnable), .oscIn(oscIn),
    .instrStart(instrStart), .instClk(instClk));
  // ****************************************
  // Bus, strobe, start-up and closing tasks
  // ****************************************
  task automatic end_sim();
    $display("Counts: checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so it is taken just after that edge.
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    busReq.rd <= 1'b0;
    #1 v = rdData;
  endtask
  task automatic strobe(input logic [1:0] k);
    @(posedge clock);
    {watchdogTimeout, wakeEvent, sleepReq} <= 3'b001 << k;
    @(posedge clock);
    {watchdogTimeout, wakeEvent, sleepReq} <= 3'b000;
  endtask
  task automatic startup(input pmc_osc_mode_type md, input logic pw, output int hi, output int rdy);
    @(posedge clock);
    sys_rst <= 1'b1;
    cfgOscMode <= md;
    cfgPwrtEnable <= pw;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    hi = 0;
    rdy = 0;
    while (cpuReady !== 1'b1 && rdy < 6000)
    begin
      @(posedge clock);
      #1;
      rdy++;
      if (holdReset === 1'b1)
        hi = rdy;
    end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    errors = 0;
    checks = 0;
    sys_rst = 1'b1;
    busReq = '0;
    {watchdogTimeout, wakeEvent, sleepReq} = 3'b000;
    cfgOscMode = OSC_FAST_XTAL_PLL;
    cfgPwrtEnable = 1'b0;
    gpio6Out = 1'b1;
    gpio6Oe = 1'b1;
    rows = '{'{1'b0, 2'b01, MODE_TIMER_RUN, SRC_TIMER, 1'b1, 1'b1}, '{1'b0, 2'b10, MODE_INT_RUN, SRC_INTERNAL, 1'b1, 1'b1},
      '{1'b0, 2'b11, MODE_INT_RUN, SRC_INTERNAL, 1'b1, 1'b1}, '{1'b1, 2'b00, MODE_MAIN_IDLE, SRC_PRIMARY, 1'b0, 1'b1},
      '{1'b1, 2'b01, MODE_TIMER_IDLE, SRC_TIMER, 1'b0, 1'b1}, '{1'b1, 2'b11, MODE_INT_IDLE, SRC_INTERNAL, 1'b0, 1'b1},
      '{1'b0, 2'b00, MODE_SLEEP, SRC_NONE, 1'b0, 1'b0}};
    startup(OSC_FAST_XTAL_PLL, 1'b0, n, m);
    `CHK(n >= 4120 && n <= 4150, 1'b1)
    `CHK(m >= n && m <= n + 3, 1'b1)
    `CHK(feedbackEnable, 1'b1)
    wr_reg(`PMC_ADDR_OSC_CTRL, 8'h82);
    startup(OSC_EXT_CLOCK_INPUT, 1'b1, n, m);
    `CHK(n >= 20 && n <= 26, 1'b1)
    `CHK(m >= 500 && m <= 502, 1'b1)
    rd_reg(`PMC_ADDR_OSC_CTRL, d);
    `CHK({d[7], d[1:0]}, 3'h0)
    rd_reg(4'hC, d);
    `CHK(d, 8'h00)
    wr_reg(`PMC_ADDR_TMR_CTRL, 8'h08);
    `WAITC(cpuClkEn === 1'b1, 100)
    $display("Test start-up done");
    foreach (rows[i])
    begin
      r = rows[i];
      wr_reg(`PMC_ADDR_OSC_CTRL, {r.halt, 3'h7, 2'b00, r.ch});
      strobe(2'd0);
      `WAITC(clkSource === r.src && periphClkEn === r.per && cpuClkEn === r.cpu, 400)
      repeat (3) @(posedge clock);
      rd_reg(`PMC_ADDR_STATUS, d);
      `CHK(d, {1'b0, r.mode, 2'b00, r.src})
      rd_reg(`PMC_ADDR_TMR_CTRL, d);
      `CHK(d[6], r.src == SRC_TIMER)
      if (r.mode == MODE_SLEEP)
      begin
        `CHK(clkOutPin, 2'b01)
        `CHK(priOscEnable, 1'b0)
      end
      strobe(2'd1);
      `WAITC(clkSource === SRC_PRIMARY && cpuClkEn === 1'b1 && periphClkEn === 1'b1, 400)
      $display("Test row %0d done", i);
    end
    wr_reg(`PMC_ADDR_TMR_CTRL, 8'h00);
    wr_reg(`PMC_ADDR_OSC_CTRL, 8'h71);
    `CHK(clkSource, SRC_PRIMARY)
    strobe(2'd0);
    repeat (80) @(posedge clock);
    rd_reg(`PMC_ADDR_STATUS, d);
    `CHK(d[1:0], 2'b00)
    `WAITC(cpuClkEn === 1'b1 && periphClkEn === 1'b1, 100)
    $display("Test disabled timer done");
    wr_reg(`PMC_ADDR_TMR_CTRL, 8'h08);
    wr_reg(`PMC_ADDR_OSC_CTRL, 8'h71);
    repeat (20) @(posedge clock);
    #1;
    `CHK(clkSource, SRC_PRIMARY)
    strobe(2'd0);
    `WAITC(clkSource === SRC_TIMER && cpuClkEn === 1'b1 && periphClkEn === 1'b1, 400)
    wr_reg(`PMC_ADDR_OSC_CTRL, 8'hF1);
    strobe(2'd0);
    `WAITC(clkSource === SRC_TIMER && cpuClkEn === 1'b0 && periphClkEn === 1'b1, 400)
    rd_reg(`PMC_ADDR_STATUS, d);
    `CHK(d, 8'h41)
    strobe(2'd2);
    `WAITC(clkSource === SRC_PRIMARY && cpuClkEn === 1'b1 && periphClkEn === 1'b1, 400)
    repeat (3) @(posedge clock);
    rd_reg(`PMC_ADDR_STATUS, d);
    `CHK(d, 8'h00)
    $display("Test run to idle done");
    startup(OSC_INTERNAL_GPIO, 1'b0, n, m);
    `CHK(n <= 2 && m >= 500 && m <= 502, 1'b1)
    `CHK(clkOutPin, 2'b11)
    wr_reg(`PMC_ADDR_OSC_CTRL, 8'h70);
    rd_reg(`PMC_ADDR_OSC_CTRL, d);
    `CHK(d, 8'h7C)
    wr_reg(`PMC_ADDR_OSC_CTRL, 8'h72);
    strobe(2'd0);
    `WAITC(clkSource === SRC_INTERNAL && cpuClkEn === 1'b1 && periphClkEn === 1'b1, 400)
    repeat (3) @(posedge clock);
    rd_reg(`PMC_ADDR_OSC_CTRL, d);
    `CHK(d, 8'h76)
    $display("Test internal primary done");
    end_sim();
  end
endmodule
